//--- rtl/mse_exec.sv
/*
 holds: execution datapath for subtract, nibble swap, exclusive-or, program rom table lookup and
 timer0 mode register move, plus its AXI4-Lite register view.
 assumes: decoder presents one operation with its register operand already read; the register file
 takes the registered write-back; program rom answers combinationally to the registered address.
*/
// Implementation choices: the register addresses and register access over AXI4-Lite.
// Behaviour
// RULE_01 - register minus working register, flags z dc c
// RULE_02 - destination bit: 0 working, 1 register
// RULE_03 - subtract carry is inverted borrow
// RULE_04 - swap nibbles, honour destination, flags kept
// RULE_05 - immediate minus working, into working, flags
// RULE_06 - lookup address pointer low bits, working; two cycles
// RULE_07 - rom word top six bits into table result
// RULE_08 - working register copied into timer mode
// RULE_09 - timer mode copied into working, flags kept
// RULE_10 - xor working with register, routed, zero only
// RULE_11 - xor working with immediate, zero only
// RULE_12 - subtract, swap, xor finish in one cycle
`timescale 1ns/1ns
`include "mse_cfg.svh"

module mse_exec (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic op_valid,
    output logic op_ready,
    input wire mse_pkg::mse_op_t op_code,
    input wire logic [`MSE_RADDR_W-1:0] op_reg_addr,
    input wire logic op_dest,
    input wire logic [`MSE_DATA_W-1:0] op_imm,
    input wire logic [`MSE_DATA_W-1:0] reg_operand,
    output logic reg_wen,
    output logic [`MSE_RADDR_W-1:0] reg_waddr,
    output logic [`MSE_DATA_W-1:0] reg_wdata,
    output logic [`MSE_DATA_W-1:0] working_register,
    output logic zero_flag,
    output logic half_carry_flag,
    output logic carry_flag,
    output logic [`MSE_DATA_W-1:0] timer_zero_mode_reg,
    output logic [`MSE_RES_W-1:0] rom_table_high_result,
    output logic [`MSE_ROM_AW-1:0] rom_addr,
    output logic rom_rd,
    input wire logic [`MSE_ROM_W-1:0] rom_data,
    input wire logic [`MSE_AXI_AW-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [`MSE_AXI_DW-1:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [`MSE_AXI_AW-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [`MSE_AXI_DW-1:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    import mse_pkg::*;

    mse_exec_state_t s;
    mse_exec_state_t next_s;
    mse_regbus_if bus ();

    // returns {carry, half_carry, difference} of a - b as a + ~b + 1
    function automatic logic [`MSE_DATA_W+1:0] sub8(input logic [`MSE_DATA_W-1:0] a,
                                                    input logic [`MSE_DATA_W-1:0] b);
        logic [`MSE_DATA_W:0] full;
        logic [`MSE_NIB_W:0] low;
        full = {1'b0, a} + {1'b0, ~b} + 9'h001;
        low = {1'b0, a[`MSE_NIB_W-1:0]} + {1'b0, ~b[`MSE_NIB_W-1:0]} + 5'h01;
        sub8 = {full[`MSE_DATA_W], low[`MSE_NIB_W], full[`MSE_DATA_W-1:0]};
    endfunction

    // word-aligned match of a bus address against one register offset
    function automatic logic addr_is(input logic [`MSE_AXI_AW-1:0] addr,
                                     input logic [`MSE_AXI_AW-1:0] ofs);
        addr_is = (addr[`MSE_AXI_AW-1:2] == ofs[`MSE_AXI_AW-1:2]);
    endfunction

    // zero test shared by the subtract and exclusive-or forms
    function automatic logic is_zero(input logic [`MSE_DATA_W-1:0] v);
        is_zero = (v == '0);
    endfunction

    // nibble exchange; flags are left alone by the caller
    function automatic logic [`MSE_DATA_W-1:0] nib_swap(input logic [`MSE_DATA_W-1:0] v);
        nib_swap = {v[`MSE_NIB_W-1:0], v[`MSE_DATA_W-1:`MSE_NIB_W]};
    endfunction

    // table address: low pointer bits above the working register
    function automatic logic [`MSE_ROM_AW-1:0] rom_index(input logic [`MSE_PTR_W-1:0] ptr,
                                                         input logic [`MSE_DATA_W-1:0] w);
        rom_index = {ptr, w};
    endfunction

    // status bits for the register view; bits not listed read as zero
    function automatic logic [`MSE_AXI_DW-1:0] flag_word(input logic c,
                                                         input logic dc,
                                                         input logic z);
        flag_word = `MSE_WORD_ZERO;
        flag_word[`MSE_FLAG_C] = c;
        flag_word[`MSE_FLAG_DC] = dc;
        flag_word[`MSE_FLAG_Z] = z;
    endfunction

    mse_axil_slave u_slave (
        .clk(clk),
        .reset_n(reset_n),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .bus(bus.slave)
    );

    // only the pointer is writable; everything else reads back state
    assign bus.wr_hit = addr_is(bus.wr_addr, `MSE_OFS_TBL_PTR);

    always_comb
    begin
        bus.rd_hit = 1'b1;
        bus.rd_data = `MSE_WORD_ZERO;
        if (addr_is(bus.rd_addr, `MSE_OFS_TBL_PTR))
        begin
            bus.rd_data[`MSE_PTR_W-1:0] = s.tbl_ptr;
        end
        else if (addr_is(bus.rd_addr, `MSE_OFS_TBL_RES))
        begin
            bus.rd_data[`MSE_RES_W-1:0] = s.tbl_res;
        end
        else if (addr_is(bus.rd_addr, `MSE_OFS_WORK))
        begin
            bus.rd_data[`MSE_DATA_W-1:0] = s.work;
        end
        else if (addr_is(bus.rd_addr, `MSE_OFS_FLAGS))
        begin
            bus.rd_data = flag_word(s.c, s.dc, s.z);
        end
        else if (addr_is(bus.rd_addr, `MSE_OFS_TMODE))
        begin
            bus.rd_data[`MSE_DATA_W-1:0] = s.tmode;
        end
        else
        begin
            bus.rd_hit = 1'b0;
        end
    end

    // stalls the decoder only while the rom word is being fetched
    assign op_ready = (s.st == st_idle);

    assign reg_wen = s.reg_wen;
    assign reg_waddr = s.reg_waddr;
    assign reg_wdata = s.reg_wdata;
    assign working_register = s.work;
    assign zero_flag = s.z;
    assign half_carry_flag = s.dc;
    assign carry_flag = s.c;
    assign timer_zero_mode_reg = s.tmode;
    assign rom_table_high_result = s.tbl_res;
    assign rom_addr = s.rom_addr;
    assign rom_rd = s.rom_rd;

    always_comb
    begin
        logic [`MSE_DATA_W+1:0] diff;
        logic [`MSE_DATA_W-1:0] res;
        logic route;
        diff = '0;
        res = '0;
        route = 1'b0;
        next_s = s;
        next_s.reg_wen = 1'b0;
        next_s.rom_rd = 1'b0;
        unique case (s.st)
            st_fetch:
            begin
                // second cycle: rom answers to the held address
                next_s.work = rom_data[`MSE_DATA_W-1:0]; // [RULE_06]
                next_s.tbl_res = rom_data[`MSE_ROM_W-1:`MSE_DATA_W]; // [RULE_07]
                next_s.st = st_idle; // [RULE_06]
            end
            st_idle:
            begin
                if (op_valid)
                begin
                    unique case (op_code)
                        sub_reg_minus_work:
                        begin
                            diff = sub8(reg_operand, s.work); // [RULE_01]
                            res = diff[`MSE_DATA_W-1:0];
                            route = 1'b1;
                            next_s.c = diff[`MSE_DATA_W+1]; // [RULE_03]
                            next_s.dc = diff[`MSE_DATA_W]; // [RULE_01]
                            next_s.z = is_zero(res); // [RULE_01]
                        end
                        nibble_exchange_op:
                        begin
                            res = nib_swap(reg_operand); // [RULE_04]
                            route = 1'b1;
                        end
                        sub_imm_minus_work:
                        begin
                            diff = sub8(op_imm, s.work); // [RULE_05]
                            next_s.work = diff[`MSE_DATA_W-1:0]; // [RULE_05]
                            next_s.c = diff[`MSE_DATA_W+1]; // [RULE_03]
                            next_s.dc = diff[`MSE_DATA_W]; // [RULE_05]
                            next_s.z = is_zero(diff[`MSE_DATA_W-1:0]); // [RULE_05]
                        end
                        program_rom_lookup:
                        begin
                            next_s.rom_addr = rom_index(s.tbl_ptr, s.work); // [RULE_06]
                            next_s.rom_rd = 1'b1;
                            next_s.st = st_fetch; // [RULE_06]
                        end
                        timer_mode_load_op:
                        begin
                            next_s.tmode = s.work; // [RULE_08]
                        end
                        timer_mode_read_op:
                        begin
                            next_s.work = s.tmode; // [RULE_09]
                        end
                        xor_work_with_reg:
                        begin
                            res = s.work ^ reg_operand; // [RULE_10]
                            route = 1'b1;
                            next_s.z = is_zero(res); // [RULE_10]
                        end
                        xor_work_with_imm:
                        begin
                            next_s.work = s.work ^ op_imm; // [RULE_11]
                            next_s.z = is_zero(s.work ^ op_imm); // [RULE_11]
                        end
                    endcase
                    // register-form results finish this cycle, written back at the next edge
                    if (route)
                    begin
                        if (op_dest)
                        begin
                            next_s.reg_wen = 1'b1; // [RULE_02] [RULE_12]
                            next_s.reg_waddr = op_reg_addr;
                            next_s.reg_wdata = res;
                        end
                        else
                        begin
                            next_s.work = res; // [RULE_02] [RULE_12]
                        end
                    end
                end
            end
        endcase
        // pointer write is independent of the sequencer; a lookup already issued keeps its address
        if (bus.wr_fire && bus.wr_hit && bus.wr_strb[`MSE_PTR_STRB])
        begin
            next_s.tbl_ptr = bus.wr_data[`MSE_PTR_W-1:0];
        end
    end

    // reset spelled per field so the sequencer starts idle whatever its encoding
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s.st <= st_idle;
            s.work <= `MSE_WORK_RST;
            s.z <= 1'b0;
            s.dc <= 1'b0;
            s.c <= 1'b0;
            s.tmode <= `MSE_TMODE_RST;
            s.tbl_ptr <= `MSE_PTR_RST;
            s.tbl_res <= `MSE_RES_RST;
            s.rom_addr <= '0;
            s.rom_rd <= 1'b0;
            s.reg_wen <= 1'b0;
            s.reg_waddr <= '0;
            s.reg_wdata <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end
endmodule

//--- inc/mse_cfg.svh
/*
 holds: offsets, reset values, field positions and widths of the subtract/swap/xor/table execution block.
 assumes: included by bare name; definitions only.
*/
`ifndef MSE_CFG_SVH
`define MSE_CFG_SVH

`define MSE_DATA_W 8
`define MSE_ROM_W 14
`define MSE_RADDR_W 6
`define MSE_PTR_W 3
`define MSE_RES_W 6
`define MSE_ROM_AW 11
`define MSE_NIB_W 4
`define MSE_PTR_STRB 0
`define MSE_AXI_AW 8
`define MSE_AXI_DW 32

`define MSE_OFS_TBL_PTR 8'h00
`define MSE_OFS_TBL_RES 8'h04
`define MSE_OFS_WORK 8'h08
`define MSE_OFS_FLAGS 8'h0C
`define MSE_OFS_TMODE 8'h10

`define MSE_FLAG_C 0
`define MSE_FLAG_DC 1
`define MSE_FLAG_Z 2

`define MSE_WORK_RST 8'h00
`define MSE_TMODE_RST 8'h00
`define MSE_PTR_RST 3'h0
`define MSE_RES_RST 6'h00
`define MSE_WORD_ZERO 32'h0000_0000

`define MSE_RESP_OKAY 2'h0
`define MSE_RESP_SLVERR 2'h2

`endif

//--- inc/mse_pkg.sv
/*
 holds: types of the execution block: operation codes, sequencer states, state records.
 assumes: mse_cfg.svh on the include path.
*/
`include "mse_cfg.svh"

package mse_pkg;

    typedef enum logic [2:0] {
        sub_reg_minus_work,
        nibble_exchange_op,
        sub_imm_minus_work,
        program_rom_lookup,
        timer_mode_load_op,
        timer_mode_read_op,
        xor_work_with_reg,
        xor_work_with_imm
    } mse_op_t;

    typedef enum logic {
        st_idle,
        st_fetch
    } mse_seq_t;

    typedef struct packed {
        mse_seq_t st;
        logic [`MSE_DATA_W-1:0] work;
        logic z;
        logic dc;
        logic c;
        logic [`MSE_DATA_W-1:0] tmode;
        logic [`MSE_PTR_W-1:0] tbl_ptr;
        logic [`MSE_RES_W-1:0] tbl_res;
        logic [`MSE_ROM_AW-1:0] rom_addr;
        logic rom_rd;
        logic reg_wen;
        logic [`MSE_RADDR_W-1:0] reg_waddr;
        logic [`MSE_DATA_W-1:0] reg_wdata;
    } mse_exec_state_t;

    typedef struct packed {
        logic aw_held;
        logic [`MSE_AXI_AW-1:0] awaddr;
        logic w_held;
        logic [`MSE_AXI_DW-1:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [`MSE_AXI_DW-1:0] rdata;
        logic [1:0] rresp;
    } mse_axil_state_t;

endpackage

//--- inc/mse_regbus_if.sv
/*
 holds: the internal register access path between the bus slave and the register bank.
 assumes: both ends on the same clock; read data answered combinationally.
*/
`timescale 1ns/1ns
`include "mse_cfg.svh"

interface mse_regbus_if;
    logic wr_fire;
    logic [`MSE_AXI_AW-1:0] wr_addr;
    logic [`MSE_AXI_DW-1:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic [`MSE_AXI_AW-1:0] rd_addr;
    logic [`MSE_AXI_DW-1:0] rd_data;
    logic rd_hit;

    modport slave (output wr_fire, wr_addr, wr_data, wr_strb, rd_addr, input wr_hit, rd_data, rd_hit);
    modport regs (input wr_fire, wr_addr, wr_data, wr_strb, rd_addr, output wr_hit, rd_data, rd_hit);
endinterface

//--- rtl/mse_axil_slave.sv
/*
 holds: AXI4-Lite slave front end, one write and one read outstanding.
 assumes: register bank on the regs modport decodes and answers in the same cycle.
*/
`timescale 1ns/1ns
`include "mse_cfg.svh"

module mse_axil_slave (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [`MSE_AXI_AW-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [`MSE_AXI_DW-1:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [`MSE_AXI_AW-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [`MSE_AXI_DW-1:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    mse_regbus_if.slave bus
);
    import mse_pkg::*;

    mse_axil_state_t s;
    mse_axil_state_t next_s;

    // address and data may arrive in either order; both held before the write fires
    assign s_awready = !s.aw_held && !s.bvalid;
    assign s_wready = !s.w_held && !s.bvalid;
    assign s_arready = !s.rvalid;
    assign s_bvalid = s.bvalid;
    assign s_bresp = s.bresp;
    assign s_rvalid = s.rvalid;
    assign s_rdata = s.rdata;
    assign s_rresp = s.rresp;

    assign bus.wr_fire = s.aw_held && s.w_held && !s.bvalid;
    assign bus.wr_addr = s.awaddr;
    assign bus.wr_data = s.wdata;
    assign bus.wr_strb = s.wstrb;
    assign bus.rd_addr = s_araddr;

    always_comb
    begin
        next_s = s;
        if (s_awvalid && s_awready)
        begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = s_awaddr;
        end
        if (s_wvalid && s_wready)
        begin
            next_s.w_held = 1'b1;
            next_s.wdata = s_wdata;
            next_s.wstrb = s_wstrb;
        end
        if (bus.wr_fire)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = bus.wr_hit ? `MSE_RESP_OKAY : `MSE_RESP_SLVERR;
        end
        if (s.bvalid && s_bready)
        begin
            next_s.bvalid = 1'b0;
        end
        if (s_arvalid && s_arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata = bus.rd_hit ? bus.rd_data : `MSE_WORD_ZERO;
            next_s.rresp = bus.rd_hit ? `MSE_RESP_OKAY : `MSE_RESP_SLVERR;
        end
        if (s.rvalid && s_rready)
        begin
            next_s.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end
endmodule

//--- verif/mse_rom_model.sv
/*
 holds: program rom model for the execution block, a fixed word per address.
 assumes: read is combinational on rom_addr while rom_rd is high.
*/
`timescale 1ns/1ns

module mse_rom_model (
    input wire logic [10:0] rom_addr,
    input wire logic rom_rd,
    output logic [13:0] rom_data
);
    logic [13:0] word;
    // every address bit shows up somewhere in the word, so a wrong address is visible
    assign word = {rom_addr[10:8] ^ 3'h5, rom_addr[2:0], rom_addr[7:0] ^ 8'h3c};
    // outside a read the lines show the inverse, never a stale match
    assign rom_data = rom_rd ? word : ~word;
endmodule

//--- verif/mse_exec_assertions.sv
/*
 holds: concurrent checks on the execution block's operation port.
 assumes: bound to mse_exec; one clock domain, async active-low reset.
*/
`timescale 1ns/1ns
`include "mse_cfg.svh"

module mse_exec_assertions
    import mse_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire logic op_ready,
    input wire mse_op_t op_code,
    input wire logic op_dest,
    input wire logic [7:0] op_imm,
    input wire logic [7:0] reg_operand,
    input wire logic reg_wen,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] working_register,
    input wire logic zero_flag,
    input wire logic half_carry_flag,
    input wire logic carry_flag,
    input wire logic [7:0] timer_zero_mode_reg,
    input wire logic [5:0] rom_table_high_result,
    input wire logic [10:0] rom_addr,
    input wire logic rom_rd,
    input wire logic [13:0] rom_data
);
    logic take;
    logic [7:0] swp;
    assign take = op_valid && op_ready;
    assign swp = {reg_operand[3:0], reg_operand[7:4]};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sub_reg_wb_a: assert property (take && op_code == sub_reg_minus_work && op_dest |=>
        reg_wen && reg_wdata == 8'($past(reg_operand) - $past(working_register)))
        else $error("register subtract write-back wrong");
    sub_carry_a: assert property (take && op_code == sub_reg_minus_work |=>
        carry_flag == ($past(reg_operand) >= $past(working_register))) else $error("subtract carry wrong");
    swap_res_a: assert property (take && op_code == nibble_exchange_op && !op_dest |=>
        working_register == $past(swp) && $stable({zero_flag, half_carry_flag, carry_flag}))
        else $error("swap result or flags wrong");
    sub_imm_a: assert property (take && op_code == sub_imm_minus_work |=>
        working_register == 8'($past(op_imm) - $past(working_register)) && zero_flag == (working_register == 8'h00))
        else $error("immediate subtract wrong");
    lookup_issue_a: assert property (take && op_code == program_rom_lookup |=>
        rom_rd && !op_ready && rom_addr[7:0] == $past(working_register)) else $error("lookup issue wrong");
    lookup_load_a: assert property (rom_rd |=>
        {rom_table_high_result, working_register} == $past(rom_data) && op_ready) else $error("lookup load wrong");
    tmode_load_a: assert property (take && op_code == timer_mode_load_op |=>
        timer_zero_mode_reg == $past(working_register)) else $error("timer mode load wrong");
    tmode_read_a: assert property (take && op_code == timer_mode_read_op |=>
        working_register == $past(timer_zero_mode_reg) && $stable(zero_flag)) else $error("timer mode read wrong");
    xor_reg_route_a: assert property (take && op_code == xor_work_with_reg && op_dest |=>
        reg_wen && reg_wdata == ($past(reg_operand) ^ $past(working_register)) && $stable(working_register))
        else $error("register xor wrong");
    xor_imm_a: assert property (take && op_code == xor_work_with_imm |=>
        working_register == ($past(op_imm) ^ $past(working_register)) && $stable(carry_flag))
        else $error("immediate xor wrong");
    single_cycle_a: assert property (take && op_code != program_rom_lookup |=> op_ready)
        else $error("op not single cycle");

    lookup_c: cover property (take && op_code == program_rom_lookup);
    borrow_c: cover property (take && op_code == sub_reg_minus_work ##1 !carry_flag);
    xor_zero_c: cover property (take && op_code == xor_work_with_imm ##1 zero_flag);
endmodule

bind mse_exec mse_exec_assertions i_chk (.*);

//--- verif/tb.sv
/*
 holds: self-checking bench for the execution block, rom model on the far side.
 assumes: 25 MHz clock; results visible one edge after an op is taken.
*/
`timescale 1ns/1ns
`include "mse_cfg.svh"

module tb;
    import mse_pkg::*;
    logic clk, reset_n, op_valid, op_ready, op_dest, reg_wen, zero_flag, half_carry_flag, carry_flag, rom_rd;
    mse_op_t op_code;
    logic [5:0] op_reg_addr, reg_waddr, rom_table_high_result;
    logic [7:0] op_imm, reg_operand, reg_wdata, working_register, timer_zero_mode_reg, s_awaddr, s_araddr;
    logic [10:0] rom_addr;
    logic [13:0] rom_data;
    logic [31:0] s_wdata, s_rdata, d;
    logic [3:0] s_wstrb;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
    logic [1:0] s_bresp, s_rresp, r;
    logic cap_wen, cap_rd, cap_rdy;
    logic [7:0] cap_wd;
    logic [10:0] cap_addr;
    int n_fail, compares, cyc;

    mse_exec i_dut (.*);
    mse_rom_model i_rom (.*);

    initial
    begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    task print_verdict;
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            print_verdict;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // offers one op, then captures the cycle after it is taken
    task op(input mse_op_t c, input logic dst, input logic [7:0] imm, input logic [7:0] rop);
        op_code <= c;
        op_dest <= dst;
        op_imm <= imm;
        reg_operand <= rop;
        op_valid <= 1'b1;
        do @(posedge clk); while (op_ready !== 1'b1);
        op_valid <= 1'b0;
        @(posedge clk);
        cap_wen = reg_wen;
        cap_wd = reg_wdata;
        cap_rd = rom_rd;
        cap_rdy = op_ready;
        cap_addr = rom_addr;
    endtask

    task axi_wr(input logic [7:0] a, input logic [31:0] v);
        s_awaddr <= a;
        s_wdata <= v;
        s_wstrb <= 4'h1;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_awvalid && s_awready)
                s_awvalid <= 1'b0;
            if (s_wvalid && s_wready)
                s_wvalid <= 1'b0;
        end
        while (s_bvalid !== 1'b1);
        r = s_bresp;
        s_bready <= 1'b0;
    endtask

    task axi_rd(input logic [7:0] a);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_arvalid && s_arready)
                s_arvalid <= 1'b0;
        end
        while (s_rvalid !== 1'b1);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
        @(posedge clk);
    endtask

    task t_sub;
        op(xor_work_with_imm, 0, 8'h06, 8'h00);
        op(sub_reg_minus_work, 1, 8'h00, 8'h05);
        chk({cap_wen, cap_wd}, 9'h1ff);
        chk({zero_flag, half_carry_flag, carry_flag}, 3'b000);
        chk(working_register, 8'h06);
        op(sub_reg_minus_work, 0, 8'h00, 8'h06);
        chk({cap_wen, working_register, zero_flag, half_carry_flag, carry_flag}, 12'h007);
        op(xor_work_with_imm, 0, 8'h05, 8'h00);
        op(sub_imm_minus_work, 1, 8'h06, 8'h00);
        chk({working_register, zero_flag, half_carry_flag, carry_flag}, 11'h00b);
        op(sub_imm_minus_work, 0, 8'h10, 8'h00);
        chk({working_register, zero_flag, half_carry_flag, carry_flag}, 11'h079);
    endtask

    task t_swap_xor;
        op_reg_addr <= 6'h3f;
        op(nibble_exchange_op, 1, 8'h00, 8'ha5);
        chk({cap_wen, cap_wd, working_register}, 17'h15a0f);
        chk(reg_waddr, 6'h3f);
        op(nibble_exchange_op, 0, 8'h00, 8'h3c);
        chk({working_register, zero_flag, half_carry_flag, carry_flag}, 11'h619);
        op(xor_work_with_imm, 0, 8'h33, 8'h00);
        op_reg_addr <= 6'h15;
        op(xor_work_with_reg, 1, 8'h00, 8'ha5);
        chk({cap_wen, cap_wd, working_register}, 17'h155f0);
        chk(reg_waddr, 6'h15);
        op(xor_work_with_imm, 0, 8'hf0, 8'h00);
        chk({working_register, zero_flag, half_carry_flag, carry_flag}, 11'h005);
    endtask

    task t_tmode;
        op(xor_work_with_imm, 0, 8'haa, 8'h00);
        op(timer_mode_load_op, 0, 8'h00, 8'h00);
        chk(timer_zero_mode_reg, 8'haa);
        op(xor_work_with_imm, 0, 8'haa, 8'h00);
        op(timer_mode_read_op, 0, 8'h00, 8'h00);
        // zero stays set although the working register is now nonzero
        chk({working_register, zero_flag, half_carry_flag, carry_flag}, 11'h555);
    endtask

    task t_lookup;
        axi_wr(8'h00, 32'hffff_fffa);
        chk(r, 2'h0);
        op(xor_work_with_imm, 0, 8'h9e, 8'h00);
        op(program_rom_lookup, 0, 8'h00, 8'h00);
        chk({cap_rd, cap_rdy, cap_addr}, 13'h1234);
        @(posedge clk);
        chk({rom_table_high_result, working_register}, 14'h3c08);
        axi_rd(8'h04);
        chk(d, 32'h0000_003c);
        axi_rd(8'h0c);
        chk(d, 32'h0000_0001);
        axi_rd(8'h20);
        chk(r, 2'h2);
        chk(d, 32'h0000_0000);
        axi_wr(8'h08, 32'h0000_0055);
        chk(r, 2'h2);
        axi_rd(8'h08);
        chk(d, 32'h0000_0008);
        axi_rd(8'h10);
        chk(d, 32'h0000_00aa);
    endtask

    initial
    begin
        {reset_n, op_valid, op_dest, op_imm, reg_operand, op_reg_addr} = '0;
        op_code = sub_reg_minus_work;
        {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready, s_araddr, s_arvalid, s_rready} = '0;
        n_fail = 0;
        compares = 0;
        cyc = 0;
        repeat (16) @(posedge clk);
        chk({op_ready, s_awready, s_wready, s_arready, reg_wen, rom_rd, s_bvalid, s_rvalid}, 8'hf0);
        chk({working_register, timer_zero_mode_reg, rom_table_high_result}, 22'h00_0000);
        reset_n <= 1'b1;
        t_sub;
        t_swap_xor;
        t_tmode;
        t_lookup;
        print_verdict;
    end
endmodule
